// *** msd_pkg.sv ***
package msd_pkg;
   // ---------------------------------------------------------------
   // Program memory layout
   // ---------------------------------------------------------------
   localparam logic [15:0] MSD_RESET_ENTRY = 16'h0000;
   localparam logic [15:0] MSD_VEC_BASE = 16'h0003;
   localparam int MSD_VEC_SHIFT = 3;
   localparam int MSD_VEC_IDX_W = 4;
   // ---------------------------------------------------------------
   // Internal data layout
   // ---------------------------------------------------------------
   localparam logic [7:0] MSD_LOWER_TOP = 8'h7f;
   localparam logic [3:0] MSD_BIT_AREA_HI = 4'h2;
   localparam int MSD_BANK_SEL_W = 2;
   localparam int MSD_BANK_REG_W = 3;
   typedef enum logic [1:0] {MSD_T_LOWER, MSD_T_UPPER, MSD_T_SPECIAL} msd_target_t;
   // ---------------------------------------------------------------
   // External move
   // ---------------------------------------------------------------
   localparam int MSD_ERAM_AW = 10;
   localparam int MSD_ERAM_DEPTH = 1024;
   localparam logic [15:0] MSD_ERAM_TOP = 16'h03ff;
   localparam logic [7:0] MSD_P0_FILL = 8'hff;
   localparam logic [7:0] MSD_P0_RESET = 8'hff;
   localparam logic [7:0] MSD_MISS_DATA = 8'hff;
   localparam logic [1:0] MSD_STROBE_CYCLES = 2'h2;
   typedef enum logic [2:0] {MSD_X_IDLE, MSD_X_RAM, MSD_X_LATCH, MSD_X_ADDR, MSD_X_DATA, MSD_X_STB,
                             MSD_X_END} msd_xstate_t;
endpackage

// *** msd_if.sv ***
`timescale 1ns/1ps
interface msd_eram_if;
   import msd_pkg::*;
   logic en;
   logic we;
   logic [MSD_ERAM_AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output en, output we, output addr, output wdata, input rdata);
   modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

interface msd_idec_if;
   import msd_pkg::*;
   logic [7:0] addr;
   logic indirect;
   logic reg_form;
   logic [MSD_BANK_REG_W-1:0] reg_index;
   logic [MSD_BANK_SEL_W-1:0] bank;
   logic bit_form;
   msd_target_t target;
   logic [7:0] byte_addr;
   logic [2:0] bit_pos;
   logic bit_ok;
   modport core (output addr, output indirect, output reg_form, output reg_index, output bank,
                 output bit_form, input target, input byte_addr, input bit_pos, input bit_ok);
   modport dec (input addr, input indirect, input reg_form, input reg_index, input bank,
                input bit_form, output target, output byte_addr, output bit_pos, output bit_ok);
endinterface

// *** msd_onchip_expanded_ram.sv ***
`timescale 1ns/1ps
module msd_eram
   import msd_pkg::*;
(
   input wire logic ref_clk,
   msd_eram_if.mem bus
);
   // One-cycle read latency, write-first is not needed by the core
   logic [7:0] mem [MSD_ERAM_DEPTH];
   logic [7:0] rdata_reg;

   always_ff @(posedge ref_clk) begin
      if (bus.en && bus.we) begin
         mem[bus.addr] <= bus.wdata;
      end
      if (bus.en) begin
         rdata_reg <= mem[bus.addr];
      end
   end

   assign bus.rdata = rdata_reg;
endmodule // msd_eram

// *** msd_idata_decode.sv ***
`timescale 1ns/1ps
module msd_idata_decode
   import msd_pkg::*;
(
   msd_idec_if.dec d
);
   always_comb begin
      d.bit_pos = 3'h0;
      d.bit_ok = 1'b0;
      if (d.reg_form) begin
         d.target = MSD_T_LOWER;
         d.byte_addr = {3'h0, d.bank, d.reg_index};
      end else if (d.bit_form) begin
         d.bit_pos = d.addr[2:0];
         d.bit_ok = 1'b1;
         if (d.addr <= MSD_LOWER_TOP) begin
            d.target = MSD_T_LOWER;
            d.byte_addr = {MSD_BIT_AREA_HI, d.addr[6:3]};
         end else begin
            d.target = MSD_T_SPECIAL;
            d.byte_addr = {d.addr[7:3], 3'h0};
         end
      end else if (d.addr <= MSD_LOWER_TOP) begin
         d.target = MSD_T_LOWER;
         d.byte_addr = d.addr;
      end else if (d.indirect) begin
         d.target = MSD_T_UPPER;
         d.byte_addr = d.addr;
      end else begin
         d.target = MSD_T_SPECIAL;
         d.byte_addr = d.addr;
      end
   end
endmodule // msd_idata_decode

// *** msd_top.sv ***
`timescale 1ns/1ps
module msd_top
   import msd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   // Program flow
   input wire logic pc_step,
   input wire logic pc_jump,
   input wire logic [15:0] pc_target,
   input wire logic irq_take,
   input wire logic [MSD_VEC_IDX_W-1:0] irq_index,
   output logic [15:0] prog_addr,
   output logic program_store_strobe_n,
   // Internal data decode
   input wire logic idata_req,
   input wire logic [7:0] idata_addr,
   input wire logic idata_indirect,
   input wire logic idata_reg_form,
   input wire logic [MSD_BANK_REG_W-1:0] idata_reg_index,
   input wire logic idata_bit_form,
   input wire logic [7:0] program_status_word,
   output logic idata_valid,
   output logic idata_sel_lower,
   output logic idata_sel_upper,
   output logic idata_sel_special,
   output logic [7:0] idata_byte_addr,
   output logic [2:0] idata_bit_pos,
   output logic idata_bit_ok,
   // External move request
   input wire logic xmov_req,
   input wire logic xmov_write,
   input wire logic xmov_wide,
   input wire logic [15:0] xmov_addr,
   input wire logic [7:0] xmov_wdata,
   output logic xmov_busy,
   output logic xmov_done,
   output logic [7:0] xmov_rdata,
   // Control bits
   input wire logic external_ram_select,
   input wire logic latch_strobe_pin_a_select,
   input wire logic latch_strobe_pin_b_select,
   // Port latches
   input wire logic p0_latch_wr,
   input wire logic [7:0] p0_latch_wdata,
   output logic [7:0] p0_latch,
   input wire logic [7:0] p2_latch,
   // Pins
   input wire logic [7:0] p0_in,
   output logic [7:0] p0_out,
   output logic p0_oe,
   output logic [7:0] p2_out,
   output logic latch_strobe_pin_a,
   output logic latch_strobe_pin_b,
   output logic rd_n,
   output logic wr_n
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] pc;
      logic idv;
      msd_target_t tgt;
      logic [7:0] ibyte;
      logic [2:0] ibit;
      logic ibit_ok;
      msd_xstate_t xs;
      logic [1:0] cnt;
      logic wr;
      logic wide;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic done;
      logic [7:0] p0l;
      logic [7:0] p0o;
      logic p0e;
      logic [7:0] p2o;
      logic stb;
      logic rdn;
      logic wrn;
   } msd_state_t;

   msd_state_t st_reg;
   msd_state_t st_next;

   msd_eram_if xr ();
   msd_idec_if id ();

   msd_eram u_eram (
      .ref_clk(ref_clk),
      .bus(xr.mem)
   );

   msd_idata_decode u_idec (
      .d(id.dec)
   );

   // ---------------------------------------------------------------
   // Internal data decode feed
   // ---------------------------------------------------------------
   // Bank select sits in bits 4:3 of the status word
   assign id.addr = idata_addr;
   assign id.indirect = idata_indirect;
   assign id.reg_form = idata_reg_form;
   assign id.reg_index = idata_reg_index;
   assign id.bank = program_status_word[4:3];
   assign id.bit_form = idata_bit_form;

   // Expanded RAM is only touched from the idle state
   logic eram_hit;
   assign eram_hit = xmov_req && !external_ram_select && (xmov_addr <= MSD_ERAM_TOP);
   assign xr.en = (st_reg.xs == MSD_X_IDLE) && eram_hit;
   assign xr.we = xmov_write;
   assign xr.addr = xmov_addr[MSD_ERAM_AW-1:0];
   assign xr.wdata = xmov_wdata;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.idv = idata_req;
      if (idata_req) begin
         st_next.tgt = id.target;
         st_next.ibyte = id.byte_addr;
         st_next.ibit = id.bit_pos;
         st_next.ibit_ok = id.bit_ok;
      end
      // Interrupt entry takes priority over a jump or a step
      if (irq_take) begin
         st_next.pc = MSD_VEC_BASE + (16'({irq_index}) << MSD_VEC_SHIFT);
      end else if (pc_jump) begin
         st_next.pc = pc_target;
      end else if (pc_step) begin
         st_next.pc = st_reg.pc + 16'h0001;
      end
      if (p0_latch_wr) begin
         st_next.p0l = p0_latch_wdata;
      end
      case (st_reg.xs)
         MSD_X_IDLE: begin
            if (xmov_req) begin
               st_next.wr = xmov_write;
               st_next.wide = xmov_wide;
               st_next.addr = xmov_wide ? xmov_addr : {8'h00, xmov_addr[7:0]};
               st_next.wdata = xmov_wdata;
               if (eram_hit) begin
                  st_next.xs = MSD_X_RAM;
               end else if (!external_ram_select) begin
                  // Beyond the expanded RAM with no bus: answer at once
                  st_next.rdata = MSD_MISS_DATA;
                  st_next.done = 1'b1;
               end else begin
                  st_next.xs = MSD_X_LATCH;
                  st_next.p0l = MSD_P0_FILL;
                  st_next.stb = 1'b1;
                  st_next.p0o = xmov_addr[7:0];
                  st_next.p0e = 1'b1;
                  st_next.p2o = xmov_wide ? xmov_addr[15:8] : p2_latch;
               end
            end else begin
               st_next.p0o = st_reg.p0l;
               st_next.p0e = 1'b1;
               st_next.p2o = p2_latch;
            end
         end
         MSD_X_RAM: begin
            st_next.rdata = xr.rdata;
            st_next.done = 1'b1;
            st_next.xs = MSD_X_IDLE;
         end
         MSD_X_LATCH: begin
            // Strobe falls while the low byte is still on port 0
            st_next.stb = 1'b0;
            st_next.xs = MSD_X_ADDR;
         end
         MSD_X_ADDR: begin
            if (st_reg.wr) begin
               st_next.p0o = st_reg.wdata;
            end else begin
               st_next.p0e = 1'b0;
            end
            st_next.xs = MSD_X_DATA;
         end
         MSD_X_DATA: begin
            st_next.rdn = st_reg.wr;
            st_next.wrn = !st_reg.wr;
            st_next.cnt = MSD_STROBE_CYCLES - 2'h1;
            st_next.xs = MSD_X_STB;
         end
         MSD_X_STB: begin
            if (st_reg.cnt == 2'h0) begin
               if (!st_reg.wr) begin
                  st_next.rdata = p0_in;
               end
               st_next.rdn = 1'b1;
               st_next.wrn = 1'b1;
               st_next.xs = MSD_X_END;
            end else begin
               st_next.cnt = st_reg.cnt - 2'h1;
            end
         end
         MSD_X_END: begin
            // Write data lingers one cycle past the strobe release
            st_next.p0o = st_reg.p0l;
            st_next.p0e = 1'b1;
            st_next.p2o = p2_latch;
            st_next.done = 1'b1;
            st_next.xs = MSD_X_IDLE;
         end
         default: begin
            st_next.xs = MSD_X_IDLE;
         end
      endcase
      if (!st_reg.wide && st_reg.xs != MSD_X_IDLE) begin
         st_next.p2o = p2_latch;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.pc <= MSD_RESET_ENTRY;
         st_reg.tgt <= MSD_T_LOWER;
         st_reg.xs <= MSD_X_IDLE;
         st_reg.p0l <= MSD_P0_RESET;
         st_reg.p0o <= MSD_P0_RESET;
         st_reg.p0e <= 1'b1;
         st_reg.p2o <= 8'hff;
         st_reg.rdn <= 1'b1;
         st_reg.wrn <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prog_addr = st_reg.pc;
   assign program_store_strobe_n = 1'b1;
   assign idata_valid = st_reg.idv;
   assign idata_sel_lower = st_reg.idv && (st_reg.tgt == MSD_T_LOWER);
   assign idata_sel_upper = st_reg.idv && (st_reg.tgt == MSD_T_UPPER);
   assign idata_sel_special = st_reg.idv && (st_reg.tgt == MSD_T_SPECIAL);
   assign idata_byte_addr = st_reg.ibyte;
   assign idata_bit_pos = st_reg.ibit;
   assign idata_bit_ok = st_reg.ibit_ok;
   assign xmov_busy = st_reg.xs != MSD_X_IDLE;
   assign xmov_done = st_reg.done;
   assign xmov_rdata = st_reg.rdata;
   assign p0_latch = st_reg.p0l;
   assign p0_out = st_reg.p0o;
   assign p0_oe = st_reg.p0e;
   assign p2_out = st_reg.p2o;
   assign latch_strobe_pin_a = st_reg.stb && latch_strobe_pin_a_select;
   assign latch_strobe_pin_b = st_reg.stb && latch_strobe_pin_b_select;
   assign rd_n = st_reg.rdn;
   assign wr_n = st_reg.wrn;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   reset_entry_a: assert property (@(posedge ref_clk) $rose(nrst) |-> prog_addr == MSD_RESET_ENTRY)
      else $error("fetch address not zero after reset");
   vector_place_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      irq_take |=> prog_addr == 16'h0003 + 16'($past(irq_index)) * 16'h0008)
      else $error("interrupt vector misplaced");
   direct_special_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      idata_req && !idata_reg_form && !idata_bit_form && !idata_indirect && idata_addr[7]
      |=> idata_sel_special && !idata_sel_upper)
      else $error("direct high address missed special space");
   indirect_upper_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      idata_req && !idata_reg_form && !idata_bit_form && idata_indirect && idata_addr[7]
      |=> idata_sel_upper && idata_byte_addr == $past(idata_addr))
      else $error("indirect high address missed upper RAM");
   bank_map_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      idata_req && idata_reg_form
      |=> idata_byte_addr == {3'h0, $past(program_status_word[4:3]), $past(idata_reg_index)})
      else $error("register bank address wrong");
   bit_area_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      idata_req && !idata_reg_form && idata_bit_form && !idata_addr[7]
      |=> idata_sel_lower && idata_byte_addr == 8'h20 + 8'($past(idata_addr) >> 3))
      else $error("bit address maps to wrong byte");
   eram_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_reg.xs == MSD_X_IDLE && eram_hit |=> rd_n && wr_n && !latch_strobe_pin_a
      && !latch_strobe_pin_b && $stable(p0_out) ##1 xmov_done)
      else $error("expanded RAM access touched the bus");
   ext_route_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_reg.xs == MSD_X_IDLE && xmov_req && external_ram_select
      |=> st_reg.xs == MSD_X_LATCH && p0_latch == 8'hff ##[1:6] xmov_done)
      else $error("external move not routed to bus");
   addr_at_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_reg.xs == MSD_X_LATCH |=> !st_reg.stb && $stable(p0_out) && p0_oe)
      else $error("low address not held at strobe fall");
   wdata_wrap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(wr_n) |-> $past(p0_out) == p0_out ##1 (!wr_n && $stable(p0_out)) [*1] ##1 wr_n && $stable(p0_out))
      else $error("write data not stable around strobe");
   read_sample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(rd_n) |-> xmov_rdata == $past(p0_in))
      else $error("read data not sampled before release");
   p2_high_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_reg.xs != MSD_X_IDLE && st_reg.xs != MSD_X_RAM && st_reg.wide |-> p2_out == st_reg.addr[15:8])
      else $error("high address not held on port 2");
   p2_page_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_reg.xs inside {MSD_X_ADDR, MSD_X_DATA, MSD_X_STB} && !st_reg.wide |-> p2_out == $past(p2_latch))
      else $error("port 2 latch not shown during narrow access");
   no_fetch_a: assert property (@(posedge ref_clk) disable iff (!nrst) program_store_strobe_n)
      else $error("program strobe asserted");
endmodule // msd_top

// *** msd_sram_model.sv ***
`timescale 1ns/1ps
module msd_sram_model (
   input wire logic ref_clk,
   input wire logic stb,
   input wire logic [7:0] p0_bus,
   input wire logic [7:0] hi,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic slow,
   output logic [7:0] drv
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat = 8'h00;
   logic [7:0] last = 8'h5a;
   logic late = 1'h0;
   // ---------------------------------------------------------------
   // Latch and array
   // ---------------------------------------------------------------
   always @(negedge stb) lat <= p0_bus;
   always @(posedge wr_n) mem[{hi, lat}] <= p0_bus;
   always @(posedge ref_clk) begin
      late <= !rd_n;
      if (!rd_n) begin
         last <= drv;
      end
   end
   // Slow mode answers a cycle late; a released bus never shows old data
   always @* begin
      if (!rd_n && (!slow || late)) begin
         drv = mem[{hi, lat}];
      end else begin
         drv = ~last;
      end
   end
endmodule // msd_sram_model

// *** msd_top_tb_top.sv ***
`timescale 1ns/1ps
module msd_top_tb_top;
   import msd_pkg::*;
   logic ref_clk = 1'h0, nrst = 1'h0, pc_step = 1'h0, pc_jump = 1'h0, irq_take = 1'h0;
   logic [15:0] pc_target = 16'h0000, prog_addr;
   logic [3:0] irq_index = 4'h0;
   logic idata_req = 1'h0, idata_indirect = 1'h0, idata_reg_form = 1'h0, idata_bit_form = 1'h0;
   logic [7:0] idata_addr = 8'h00, program_status_word = 8'h00, idata_byte_addr;
   logic [2:0] idata_reg_index = 3'h0, idata_bit_pos;
   logic idata_valid, idata_sel_lower, idata_sel_upper, idata_sel_special, idata_bit_ok;
   logic xmov_req = 1'h0, xmov_write = 1'h0, xmov_wide = 1'h0, xmov_busy, xmov_done;
   logic [15:0] xmov_addr = 16'h0000;
   logic [7:0] xmov_wdata = 8'h00, xmov_rdata, p0_latch, p0_out, p2_out, drv, p0_in;
   logic external_ram_select = 1'h0, latch_strobe_pin_a_select = 1'h1, latch_strobe_pin_b_select = 1'h0;
   logic p0_latch_wr = 1'h0, slow = 1'h0, prev_stb = 1'h0, prev_wr = 1'h1, quiet = 1'h0;
   logic [7:0] p0_latch_wdata = 8'h00, p2_latch = 8'h05, exp_p2 = 8'h00, exp_lo = 8'h00, exp_wd = 8'h00;
   logic program_store_strobe_n, p0_oe, latch_strobe_pin_a, latch_strobe_pin_b, rd_n, wr_n;
   logic [20:0] snap = 21'h0;
   int num_errors = 0;
   int samples_checked = 0;
   wire stb = latch_strobe_pin_a | latch_strobe_pin_b;
   wire [20:0] pins = {p0_out, p0_oe, p2_out, latch_strobe_pin_a, latch_strobe_pin_b, rd_n, wr_n};
   assign p0_in = p0_oe ? p0_out : drv;

   msd_top dut (.ref_clk, .nrst, .pc_step, .pc_jump, .pc_target, .irq_take, .irq_index, .prog_addr,
      .program_store_strobe_n, .idata_req, .idata_addr, .idata_indirect, .idata_reg_form, .idata_reg_index,
      .idata_bit_form, .program_status_word, .idata_valid, .idata_sel_lower, .idata_sel_upper,
      .idata_sel_special, .idata_byte_addr, .idata_bit_pos, .idata_bit_ok, .xmov_req, .xmov_write,
      .xmov_wide, .xmov_addr, .xmov_wdata, .xmov_busy, .xmov_done, .xmov_rdata, .external_ram_select,
      .latch_strobe_pin_a_select, .latch_strobe_pin_b_select, .p0_latch_wr, .p0_latch_wdata, .p0_latch,
      .p2_latch, .p0_in, .p0_out, .p0_oe, .p2_out, .latch_strobe_pin_a, .latch_strobe_pin_b, .rd_n, .wr_n);
   msd_sram_model far_ram (.ref_clk, .stb, .p0_bus(p0_in), .hi(p2_out), .rd_n, .wr_n, .slow, .drv);

   always #50 ref_clk = ~ref_clk;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("Errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic prog(input logic s, j, i, input logic [3:0] x, input logic [15:0] t, e);
      @(negedge ref_clk);
      pc_step = s;
      pc_jump = j;
      irq_take = i;
      irq_index = x;
      pc_target = t;
      @(negedge ref_clk);
      {pc_step, pc_jump, irq_take} = 3'h0;
      check(prog_addr, e);
   endtask

   task automatic dec(input logic ind, rf, bf, input logic [2:0] idx, input logic [7:0] a, sw,
                      input logic [2:0] sel, input logic [7:0] ba, input logic [2:0] bp);
      @(negedge ref_clk);
      {idata_indirect, idata_reg_form, idata_bit_form} = {ind, rf, bf};
      idata_reg_index = idx;
      idata_addr = a;
      program_status_word = sw;
      idata_req = 1'h1;
      @(negedge ref_clk);
      idata_req = 1'h0;
      check({idata_valid, idata_sel_lower, idata_sel_upper, idata_sel_special, idata_byte_addr},
            {1'h1, sel, ba});
      check({idata_bit_pos, idata_bit_ok}, bf ? {bp, 1'h1} : 4'h0);
   endtask

   task automatic p0_set(input logic [7:0] v);
      @(negedge ref_clk);
      p0_latch_wr = 1'h1;
      p0_latch_wdata = v;
      @(negedge ref_clk);
      p0_latch_wr = 1'h0;
   endtask

   // Waits for done under a bound; lat counts cycles from the request being placed
   task automatic xmov(input logic w, wd, input logic [15:0] a, input logic [7:0] d, input int lat);
      int n;
      @(negedge ref_clk);
      exp_p2 = wd ? a[15:8] : p2_latch;
      exp_lo = a[7:0];
      exp_wd = d;
      snap = pins;
      quiet = !external_ram_select;
      {xmov_req, xmov_write, xmov_wide, xmov_addr, xmov_wdata} = {1'h1, w, wd, a, d};
      @(negedge ref_clk);
      xmov_req = 1'h0;
      check({xmov_busy, latch_strobe_pin_a, latch_strobe_pin_b}, {lat > 1, !quiet & latch_strobe_pin_a_select,
            !quiet & latch_strobe_pin_b_select});
      n = 1;
      while (xmov_done !== 1'h1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      check(24'(n), 24'(lat));
      quiet = 1'h0;
   endtask

   // ---------------------------------------------------------------
   // Bus monitor
   // ---------------------------------------------------------------
   always @(negedge ref_clk) begin
      if (nrst && xmov_busy === 1'h1 && external_ram_select) begin
         check(p2_out, exp_p2);
         check({latch_strobe_pin_a & !latch_strobe_pin_a_select, latch_strobe_pin_b & !latch_strobe_pin_b_select},
               2'h0);
      end
      if (prev_stb && !stb) check({p0_oe, p0_out}, {1'h1, exp_lo});
      if (prev_wr != wr_n) check({p0_oe, p0_out}, {1'h1, exp_wd});
      if (quiet) check(pins, snap);
      prev_stb <= stb;
      prev_wr <= wr_n;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(negedge ref_clk);
      nrst = 1'h1;
      check({prog_addr, program_store_strobe_n}, {16'h0000, 1'h1});
      check({p0_latch, p0_out, rd_n, wr_n}, {8'hff, 8'hff, 2'h3});
      prog(1'h1, 1'h0, 1'h0, 4'h0, 16'h0000, 16'h0001);
      for (int k = 0; k < 16; k++) prog(1'h1, 1'h1, 1'h1, 4'(k), 16'h4321, 16'h0003 + 16'(k * 8));
      prog(1'h1, 1'h1, 1'h0, 4'h0, 16'hbeef, 16'hbeef);
      dec(1'h0, 1'h0, 1'h0, 3'h0, 8'h7f, 8'h00, 3'h4, 8'h7f, 3'h0);
      dec(1'h1, 1'h0, 1'h0, 3'h0, 8'h7f, 8'h00, 3'h4, 8'h7f, 3'h0);
      dec(1'h0, 1'h0, 1'h0, 3'h0, 8'h80, 8'h00, 3'h1, 8'h80, 3'h0);
      dec(1'h1, 1'h0, 1'h0, 3'h0, 8'hff, 8'h00, 3'h2, 8'hff, 3'h0);
      for (int b = 0; b < 4; b++) dec(1'h0, 1'h1, 1'h0, 3'(7 * (b % 2)), 8'h99, 8'he7 | 8'(b << 3), 3'h4,
                                      8'(b * 8 + 7 * (b % 2)), 3'h0);
      dec(1'h0, 1'h0, 1'h1, 3'h0, 8'h00, 8'h00, 3'h4, 8'h20, 3'h0);
      dec(1'h0, 1'h0, 1'h1, 3'h0, 8'h7f, 8'h00, 3'h4, 8'h2f, 3'h7);
      dec(1'h0, 1'h0, 1'h1, 3'h0, 8'h8f, 8'h00, 3'h1, 8'h88, 3'h7);
      dec(1'h0, 1'h0, 1'h1, 3'h0, 8'hf0, 8'h00, 3'h1, 8'hf0, 3'h0);
      p0_set(8'h3c);
      external_ram_select = 1'h1;
      xmov(1'h1, 1'h1, 16'h1234, 8'ha5, 7);
      check(p0_latch, 8'hff);
      xmov(1'h1, 1'h1, 16'h03ff, 8'h11, 7);
      xmov(1'h1, 1'h0, 16'hbe77, 8'h5a, 7);
      {latch_strobe_pin_a_select, latch_strobe_pin_b_select, slow} = 3'h3;
      xmov(1'h0, 1'h1, 16'h1234, 8'h00, 7);
      check(xmov_rdata, 8'ha5);
      {latch_strobe_pin_a_select, latch_strobe_pin_b_select, slow} = 3'h4;
      xmov(1'h0, 1'h1, 16'h0577, 8'h00, 7);
      check(xmov_rdata, 8'h5a);
      xmov(1'h0, 1'h0, 16'h5577, 8'h00, 7);
      check(xmov_rdata, 8'h5a);
      p0_set(8'h3c);
      external_ram_select = 1'h0;
      xmov(1'h1, 1'h1, 16'h03ff, 8'h66, 2);
      xmov(1'h1, 1'h1, 16'h0000, 8'h77, 2);
      xmov(1'h0, 1'h1, 16'h03ff, 8'h00, 2);
      check(xmov_rdata, 8'h66);
      xmov(1'h0, 1'h1, 16'h0000, 8'h00, 2);
      check(xmov_rdata, 8'h77);
      xmov(1'h0, 1'h1, 16'h0400, 8'h00, 1);
      check({xmov_rdata, p0_latch}, {8'hff, 8'h3c});
      external_ram_select = 1'h1;
      xmov(1'h0, 1'h1, 16'h03ff, 8'h00, 7);
      check({xmov_rdata, p0_latch}, {8'h11, 8'hff});
      final_report;
   end

   // Whole run needs about 140 cycles; the limit leaves ample room
   initial begin
      #500000;
      num_errors++;
      final_report;
   end
endmodule // msd_top_tb_top
